// ---- rtl/gate_drive_end.sv ----
/*
   Device end: decodes three-level PWM and skip codes into gate commands,
   with device-side zero-current detection in skip-high mode.
   Assumes switch_node_sense is an asynchronous comparator output.
*/
// Function
// - Skip high: high-PWM gives high side, low-PWM low side
// - Controller drives skip high or floats it
// - Undriven skip input reads as high
// - Continuous conduction toggles only high and low
// - Controller enters discontinuous mode with mid PWM
// - Skip high, mid PWM: low side on
// - Low side held through debounce and blanking
// - Then comparator trip turns low side off
// - Controller-side detection holds skip low
// - Skip low: mid PWM turns both gates off
// - Skip low: controller detects zero current itself
// - Controller signals zero current with mid PWM
// - Skip low, mid entry: both off at once
// - Debounce lasts 80 ns; the code rounds it up to one 100 ns cycle
// - Skip mid decodes as skip high
// - Early zero-current ignored until timers end
`timescale 1ns/1ps
module gate_drive_end #(
   parameter int BLANK_CYC = gate_ctrl_pkg::BLANK_CYC_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   gate_ctrl_if.dev_end link,
   // Gate commands
   output logic high_side_gate,
   output logic low_side_gate,
   // Status
   output logic zcd_waiting
);
   import gate_ctrl_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_RUN  = 2'h0,
      ST_WAIT = 2'h1,
      ST_MON  = 2'h2,
      ST_IDLE = 2'h3
   } zcd_st_t;

   typedef struct packed {
      logic [2:0] sense_sync;
      logic sense;
      zcd_st_t st;
      logic [TIMER_W-1:0] timer;
      level_t pwm_prev;
      logic hs;
      logic ls;
      logic waiting;
   } dev_state_t;

   localparam logic [TIMER_W-1:0] WAIT_CYC = TIMER_W'(DEBOUNCE_CYC + BLANK_CYC);

   dev_state_t cur_ff;
   dev_state_t nxt_cur;
   level_t skip_eff;
   logic skip_high_mode;

   // ----------------------------------------
   // Input decode
   // ----------------------------------------
   always_comb begin
      // Pull-up makes a floating pin read high
      skip_eff = link.skip_mode_n_oe ? link.skip_mode_n : LVL_HIGH;
      skip_high_mode = (skip_eff != LVL_LOW);
   end

   always_comb begin
      nxt_cur = cur_ff;
      // Three-stage sync; change counts when stages two and three agree
      nxt_cur.sense_sync = {cur_ff.sense_sync[1:0], link.switch_node_sense};
      if (cur_ff.sense_sync[2] == cur_ff.sense_sync[1]) begin
         nxt_cur.sense = cur_ff.sense_sync[2];
      end
      nxt_cur.pwm_prev = link.pwm_level;
      nxt_cur.st = ST_RUN;
      nxt_cur.timer = RST_TIMER;
      unique case (link.pwm_level)
         LVL_HIGH: begin
            nxt_cur.hs = 1'h1;
            nxt_cur.ls = 1'h0;
         end
         LVL_LOW: begin
            nxt_cur.hs = 1'h0;
            nxt_cur.ls = 1'h1;
         end
         LVL_MID: begin
            nxt_cur.hs = 1'h0;
            if (!skip_high_mode) begin
               nxt_cur.ls = 1'h0;
               nxt_cur.st = ST_IDLE;
            end else if (cur_ff.pwm_prev != LVL_MID || cur_ff.st == ST_RUN
                         || cur_ff.st == ST_IDLE) begin
               nxt_cur.ls = 1'h1;
               nxt_cur.st = ST_WAIT;
               nxt_cur.timer = WAIT_CYC;
            end else begin
               nxt_cur.st = cur_ff.st;
               nxt_cur.timer = cur_ff.timer;
               unique case (cur_ff.st)
                  ST_WAIT: begin
                     // Early trips are ignored; low side drops when wait ends only if sense is already set
                     nxt_cur.ls = 1'h1;
                     if (cur_ff.timer <= TIMER_W'(1)) begin
                        nxt_cur.st = ST_MON;
                        nxt_cur.timer = RST_TIMER;
                        nxt_cur.ls = !cur_ff.sense;
                     end else begin
                        nxt_cur.timer = cur_ff.timer - TIMER_W'(1);
                     end
                  end
                  ST_MON: begin
                     if (cur_ff.sense) begin
                        nxt_cur.ls = 1'h0;
                     end
                  end
                  default: begin
                     nxt_cur.ls = 1'h0;
                  end
               endcase
            end
         end
         default: begin
            nxt_cur.hs = 1'h0;
            nxt_cur.ls = 1'h0;
         end
      endcase
      nxt_cur.waiting = (nxt_cur.st == ST_WAIT);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff <= '{sense_sync: 3'h0, sense: 1'h0, st: ST_RUN, timer: RST_TIMER,
                     pwm_prev: LVL_LOW, hs: RST_GATE, ls: RST_GATE, waiting: 1'h0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign high_side_gate = cur_ff.hs;
   assign low_side_gate = cur_ff.ls;
   assign zcd_waiting = cur_ff.waiting;

endmodule // gate_drive_end

// ---- pkg/gate_ctrl_pkg.sv ----
/*
   Shared constants and types for the three-level PWM gate-control link.
   Assumes a single 10 MHz clock with a synchronous active-high reset.
*/
package gate_ctrl_pkg;

   // ----------------------------------------
   // Three-level decoded input codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      LVL_LOW  = 2'h0,
      LVL_MID  = 2'h1,
      LVL_HIGH = 2'h2
   } level_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int DEBOUNCE_NS = 80;
   // Least time: round up, never below one cycle
   localparam int DEBOUNCE_CYC_RAW = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_CYC_RAW < 1) ? 1 : DEBOUNCE_CYC_RAW;
   localparam int BLANK_CYC_DEFAULT = 4;
   localparam int TIMER_W = 8;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic RST_GATE = 1'h0;
   localparam logic [TIMER_W-1:0] RST_TIMER = 8'h00;

endpackage

// ---- pkg/gate_ctrl_if.sv ----
/*
   Link between the controller end and the gate-control end.
   Assumes both ends share clk; the device end resolves skip_mode_n pull-up.
*/
`timescale 1ns/1ps
interface gate_ctrl_if;
   import gate_ctrl_pkg::*;

   // ----------------------------------------
   // Link signals
   // ----------------------------------------
   level_t pwm_level;
   level_t skip_mode_n;
   logic skip_mode_n_oe;
   logic switch_node_sense;

   modport ctrl_end (
      output pwm_level,
      output skip_mode_n,
      output skip_mode_n_oe,
      input switch_node_sense
   );

   modport dev_end (
      input pwm_level,
      input skip_mode_n,
      input skip_mode_n_oe,
      input switch_node_sense
   );

endinterface

// ---- rtl/pwm_ctrl_end.sv ----
/*
   Controller end: turns user requests into three-level PWM and skip codes.
   Assumes requests are synchronous to clk.
*/
`timescale 1ns/1ps
module pwm_ctrl_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // User side
   input wire logic ctrl_zcd_mode,
   input wire logic float_skip,
   input wire logic pwm_on,
   input wire logic dcm_enter,
   input wire logic zero_current_detect,
   // Link
   gate_ctrl_if.ctrl_end link
);
   import gate_ctrl_pkg::*;

   typedef struct packed {
      level_t pwm;
      level_t skip;
      logic skip_oe;
   } ctrl_state_t;

   ctrl_state_t cur_ff;
   ctrl_state_t nxt_cur;

   always_comb begin
      nxt_cur = cur_ff;
      if (ctrl_zcd_mode) begin
         nxt_cur.skip = LVL_LOW;
         nxt_cur.skip_oe = 1'h1;
      end else begin
         nxt_cur.skip = LVL_HIGH;
         nxt_cur.skip_oe = !float_skip;
      end
      if (pwm_on) begin
         nxt_cur.pwm = LVL_HIGH;
      end else if (ctrl_zcd_mode && zero_current_detect) begin
         nxt_cur.pwm = LVL_MID;
      end else if (!ctrl_zcd_mode && dcm_enter) begin
         nxt_cur.pwm = LVL_MID;
      end else begin
         nxt_cur.pwm = LVL_LOW;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff <= '{pwm: LVL_LOW, skip: LVL_HIGH, skip_oe: 1'h0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign link.pwm_level = cur_ff.pwm;
   assign link.skip_mode_n = cur_ff.skip;
   assign link.skip_mode_n_oe = cur_ff.skip_oe;

endmodule // pwm_ctrl_end

// ---- dv/gate_ctrl_sva.sv ----
/* Assertions on the link and gate outputs.
   Instantiated in tb_top beside the interface. */
`timescale 1ns/1ps
module gate_ctrl_sva (
   // Clock, reset
   input wire logic clk,
   input wire logic rst,
   // Link and gates
   input wire gate_ctrl_pkg::level_t pwm_level,
   input wire gate_ctrl_pkg::level_t skip_mode_n,
   input wire logic skip_mode_n_oe,
   input wire logic switch_node_sense,
   input wire logic high_side_gate,
   input wire logic low_side_gate,
   input wire logic zcd_waiting
);
   import gate_ctrl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ---
   // Undriven skip reads high
   // ---
   logic skl;
   assign skl = skip_mode_n_oe && skip_mode_n == LVL_LOW;
   sequence s_mid_entry;
      pwm_level == LVL_MID && $past(pwm_level) != LVL_MID && !skl;
   endsequence
   // Wait of debounce plus default blanking: five cycles while mid holds
   sequence s_wait_start;
      $rose(zcd_waiting) ##0 (pwm_level == LVL_MID)[*5];
   endsequence
   AST_HIGH: assert property (pwm_level == LVL_HIGH |=> high_side_gate && !low_side_gate)
      else $error("high pwm gates wrong");
   AST_LOW: assert property (pwm_level == LVL_LOW |=> !high_side_gate && low_side_gate)
      else $error("low pwm gates wrong");
   AST_MID_OFF: assert property (pwm_level == LVL_MID && skl |=> !high_side_gate && !low_side_gate)
      else $error("skip low mid gates wrong");
   AST_MID_ENTRY: assert property (s_mid_entry |=> !high_side_gate && low_side_gate && zcd_waiting)
      else $error("mid entry gates wrong");
   AST_WAIT_HOLD: assert property (zcd_waiting |-> low_side_gate && !high_side_gate)
      else $error("low side dropped in wait");
   AST_WAIT_LEN: assert property (s_wait_start |-> zcd_waiting ##1 !zcd_waiting)
      else $error("wait length wrong");
   AST_MONITOR: assert property ((pwm_level == LVL_MID && !skl && !zcd_waiting && switch_node_sense)[*6] |=> !low_side_gate)
      else $error("low side kept on after trip");
   AST_EXCL: assert property (!(high_side_gate && low_side_gate))
      else $error("both gates on");
endmodule // gate_ctrl_sva

// ---- dv/tb_top.sv ----
/* Self-checking bench joining both ends.
   Drives user inputs and the switch-node comparator. */
`timescale 1ns/1ps
module tb_top;
   import gate_ctrl_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic mode = 1'h0;
   logic flt = 1'h0;
   logic on = 1'h0;
   logic dcm = 1'h0;
   logic zc = 1'h0;
   logic hs;
   logic ls;
   logic wt;
   int fail_count = 0;
   int checks = 0;
   always #50 clk = ~clk;
   gate_ctrl_if i_gate_ctrl_if ();
   pwm_ctrl_end i_pwm_ctrl_end (.clk(clk), .rst(rst), .ctrl_zcd_mode(mode), .float_skip(flt),
      .pwm_on(on), .dcm_enter(dcm), .zero_current_detect(zc), .link(i_gate_ctrl_if));
   gate_drive_end #(.BLANK_CYC(BLANK_CYC_DEFAULT)) i_gate_drive_end (.clk(clk), .rst(rst),
      .link(i_gate_ctrl_if), .high_side_gate(hs), .low_side_gate(ls), .zcd_waiting(wt));
   gate_ctrl_sva i_gate_ctrl_sva (.clk(clk), .rst(rst), .pwm_level(i_gate_ctrl_if.pwm_level),
      .skip_mode_n(i_gate_ctrl_if.skip_mode_n), .skip_mode_n_oe(i_gate_ctrl_if.skip_mode_n_oe),
      .switch_node_sense(i_gate_ctrl_if.switch_node_sense), .high_side_gate(hs),
      .low_side_gate(ls), .zcd_waiting(wt));
   // ---
   // Tasks
   // ---
   task automatic conclude;
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %b want %b", $time, seen, exp);
      end
   endtask
   task automatic req(input logic [4:0] v);
      @(posedge clk);
      {mode, flt, on, dcm, zc} <= v;
   endtask
   task automatic look(input int n, input logic [2:0] e);
      repeat (n) @(posedge clk);
      #1 chk({hs, ls, wt}, e);
   endtask
   // Bounded wait for a gate state, giving the cycles taken
   task automatic settle(input logic [2:0] e, output int k);
      k = 0;
      while ({hs, ls, wt} !== e && k < 20) begin
         @(posedge clk);
         #1 k++;
      end
      if (k == 20) begin
         fail_count++;
         conclude();
      end
   endtask
   initial begin
      int k;
      i_gate_ctrl_if.switch_node_sense = 1'h0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      look(2, 3'b010);
      // Skip driven high, floating, then low
      for (int m = 0; m < 3; m++) begin
         req({m == 2, m == 1, 3'b100});
         look(2, 3'b100);
         req({m == 2, m == 1, 3'b000});
         i_gate_ctrl_if.switch_node_sense <= (m == 1);
         look(2, 3'b010);
         req({m == 2, m == 1, 3'b100});
         req({m == 2, m == 1, 3'b011});
         look(1, 3'b100);
         look(1, m == 2 ? 3'b000 : 3'b011);
         if (m < 2) begin
            // Early trip on float pass must wait out the timers
            settle(m == 1 ? 3'b000 : 3'b010, k);
            chk(3'(k), 3'(DEBOUNCE_CYC + BLANK_CYC_DEFAULT));
         end
         if (m == 0) begin
            @(posedge clk);
            i_gate_ctrl_if.switch_node_sense <= 1'h1;
            settle(3'b000, k);
            chk(3'(k > 0 && k <= 6), 3'h1);
         end
         @(posedge clk);
         i_gate_ctrl_if.switch_node_sense <= 1'h0;
      end
      conclude();
   end
endmodule // tb_top
